//--- dv/rfio_mcu_model.sv
// Model of the external controller on the bit-stream port.
module rfio_mcu_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins as seen by the controller.
  input wire logic dclk_i,
  input wire logic data_i,
  // Driven data and last sampled bit.
  output logic drive_o,
  output logic smp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dclk_q;
  logic [7:0] pat_q;

  // Sample on the clock rise and move own data just after it, far from the next rise.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dclk_q <= 1'b0;
      pat_q <= 8'hb4;
      smp_o <= 1'b0;
    end
    else
    begin
      dclk_q <= dclk_i;
      if (dclk_i && !dclk_q)
      begin
        smp_o <= data_i;
        pat_q <= {pat_q[6:0], pat_q[7]};
      end
    end
  end
  assign drive_o = pat_q[7];
endmodule : rfio_mcu_model

//--- dv/rfio_top_chk.sv
// Concurrent checks on the ports of the pin router.
module rfio_top_chk (
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pin_route_cfg_a_i,
  input wire logic [3:0] pin_route_cfg_b_i,
  input wire rfio_pkg::rfio_mode_t chip_mode_i,
  input wire logic packet_mode_i,
  input wire logic bitsync_en_i,
  input wire logic rx_payload_avail_i,
  input wire logic tx_packet_done_i,
  input wire logic crc_good_i,
  input wire logic divided_clock_out_i,
  input wire logic mod_bit_stb_o,
  input wire logic [5:0] gp_pin_o,
  input wire logic gp_pin_2_oe_o,
  input wire logic bitsync_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode shorthands; c12 holds when the pin 1 and pin 2 codes are both 00.
  wire logic pk = packet_mode_i;
  wire logic rx = chip_mode_i == rfio_pkg::RFIO_MODE_RX;
  wire logic tx = chip_mode_i == rfio_pkg::RFIO_MODE_TX;
  wire logic c0 = pin_route_cfg_a_i[1:0] == 2'h0;
  wire logic c12 = pin_route_cfg_a_i[5:2] == 4'h0;
  wire logic act = chip_mode_i inside {rfio_pkg::RFIO_MODE_FS, rfio_pkg::RFIO_MODE_RX,
    rfio_pkg::RFIO_MODE_TX};

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_pin_unmapped: assert property (pin_route_cfg_a_i[3:2] == 2'h3 |=> !gp_pin_o[1])
    else $error("pin 1 not low on empty code");
  a_sent_route: assert property (pk && tx && c0 |=> gp_pin_o[0] == $past(tx_packet_done_i))
    else $error("pin 0 not packet done");
  a_avail_route: assert property (pk && rx && c0 |=> gp_pin_o[0] == $past(rx_payload_avail_i))
    else $error("pin 0 not payload");
  a_crc_route: assert property (pk && rx && pin_route_cfg_a_i[1:0] == 2'h1
    |=> gp_pin_o[0] == $past(crc_good_i))
    else $error("pin 0 not crc");
  a_clk_route: assert property (!pk && act && pin_route_cfg_b_i[3:2] == 2'h0
    |=> gp_pin_o[5] == $past(divided_clock_out_i))
    else $error("pin 5 not clock out");
  a_sync_forced: assert property (pk |=> bitsync_on_o)
    else $error("sync not forced");
  a_raw_no_clk: assert property ((!pk && rx && !bitsync_en_i && c12)[*3] |-> !gp_pin_o[1])
    else $error("bit clock in raw receive");
  a_stb_pulse: assert property (mod_bit_stb_o |=> !mod_bit_stb_o)
    else $error("strobe longer than one cycle");
  a_tx_on_rise: assert property (!pk && tx && c12 && mod_bit_stb_o |=> $rose(gp_pin_o[1]))
    else $error("capture not at clock rise");
  a_rx_on_fall: assert property ((!pk && rx && bitsync_en_i && c12)[*4]
    ##0 $changed(gp_pin_o[2]) |-> $fell(gp_pin_o[1]))
    else $error("data moved off the fall");
  a_tx_release: assert property ((!pk && tx)[*2] |-> !gp_pin_2_oe_o)
    else $error("data pin driven in transmit");

  c_tx_strobe: cover property (!pk && mod_bit_stb_o);
  c_full_pin: cover property (pk && pin_route_cfg_a_i[3:2] == 2'h2 && gp_pin_o[1]);
  c_rx_fall: cover property (!pk && bitsync_en_i && $fell(gp_pin_o[1]));
endmodule : rfio_top_chk

bind rfio_top rfio_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .pin_route_cfg_a_i(pin_route_cfg_a_i), .pin_route_cfg_b_i(pin_route_cfg_b_i),
  .chip_mode_i(chip_mode_i), .packet_mode_i(packet_mode_i), .bitsync_en_i(bitsync_en_i),
  .rx_payload_avail_i(rx_payload_avail_i), .tx_packet_done_i(tx_packet_done_i),
  .crc_good_i(crc_good_i), .divided_clock_out_i(divided_clock_out_i),
  .mod_bit_stb_o(mod_bit_stb_o), .gp_pin_o(gp_pin_o), .gp_pin_2_oe_o(gp_pin_2_oe_o),
  .bitsync_on_o(bitsync_on_o));

//--- dv/rfio_top_tb_top.sv
// Self-checking bench for the pin router and bit-stream port.
module rfio_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] cfg_a = 8'h00;
  logic [3:0] cfg_b = 4'h0;
  rfio_pkg::rfio_mode_t mode = rfio_pkg::RFIO_MODE_STDBY;
  logic pkt = 1'b0;
  logic bsync = 1'b0;
  logic [12:0] st = 13'h0000;
  logic tick = 1'b0;
  logic demod = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [5:0] gp;
  logic oe, mbit, stb, son, pin2, mcu_d, mcu_s;
  logic [1:0] tcnt = 2'h0;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  // The data wire carries whoever drives it.
  assign pin2 = oe ? gp[2] : mcu_d;

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  rfio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pin_route_cfg_a_i(cfg_a),
    .pin_route_cfg_b_i(cfg_b), .chip_mode_i(mode), .packet_mode_i(pkt),
    .bitsync_en_i(bsync), .queue_thresh_i(6'h20), .rx_payload_avail_i(st[0]),
    .tx_packet_done_i(st[1]), .crc_good_i(st[2]), .pattern_match_i(st[3]),
    .lead_in_seen_i(st[4]), .transmit_path_ok_i(st[5]), .receive_path_ok_i(st[6]),
    .supply_low_flag_i(st[7]), .thermal_shift_flag_i(st[8]), .synth_locked_i(st[9]),
    .chip_mode_settled_i(st[10]), .divided_clock_out_i(st[11]), .timeout_i(st[12]),
    .half_bit_tick_i(tick), .demod_bit_i(demod), .mod_bit_o(mbit), .mod_bit_stb_o(stb),
    .spi_wr_i(wr), .spi_wdata_i(wd), .spi_rd_i(rd), .spi_rdata_o(rdata), .gp_pin_o(gp),
    .gp_pin_2_i(pin2), .gp_pin_2_oe_o(oe), .bitsync_on_o(son));

  rfio_mcu_model mcu_u (.clk_i(clk_i), .rst_i(rst_i), .dclk_i(gp[1]), .data_i(pin2),
    .drive_o(mcu_d), .smp_o(mcu_s));

  // Ticks every fourth cycle give a 64 ns bit clock; a cycle cap cuts a hang short.
  always @(posedge clk_i)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic chk_bit(input logic e, input logic a);
    check_count++;
    if (a !== e)
    begin
      err_total++;
      $display("Error at %0t: exp %h got %h", $time, e, a);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] a);
    check_count++;
    if (a !== e)
    begin
      err_total++;
      $display("Error at %0t: exp %h got %h", $time, e, a);
    end
  endtask : chk_byte

  task automatic cfg(input logic p, input rfio_pkg::rfio_mode_t m, input logic [7:0] a);
    pkt <= p;
    mode <= m;
    cfg_a <= a;
    step(3);
  endtask : cfg

  // Pin 3 code 11 and pin 4 code 00 both carry the low-supply flag in synth mode.
  task automatic t_route;
    cfg(1'b0, rfio_pkg::RFIO_MODE_FS, 8'hcc);
    st <= 13'h0880;
    step(2);
    chk_bit(1'b1, gp[5]);
    chk_bit(1'b0, gp[1]);
    chk_bit(1'b1, gp[3]);
    chk_bit(1'b1, gp[4]);
    st <= 13'h0000;
    step(2);
    chk_bit(1'b0, gp[5]);
    chk_bit(1'b0, gp[3]);
    $display("route test done");
  endtask : t_route

  task automatic t_pkt;
    st[0] <= 1'b1;
    cfg(1'b1, rfio_pkg::RFIO_MODE_RX, 8'h00);
    chk_bit(1'b1, gp[0]);
    chk_bit(1'b1, son);
    cfg(1'b1, rfio_pkg::RFIO_MODE_RX, 8'h01);
    chk_bit(1'b0, gp[0]);
    st <= 13'h0006;
    cfg(1'b1, rfio_pkg::RFIO_MODE_TX, 8'h00);
    chk_bit(1'b1, gp[0]);
    st <= 13'h0000;
    $display("packet route test done");
  endtask : t_pkt

  // Fills past the top in standby, then drains to empty.
  task automatic t_fifo;
    cfg(1'b1, rfio_pkg::RFIO_MODE_STDBY, 8'h08);
    for (int i = 0; i < 65; i++)
    begin
      if (i > 62)
      begin
        step(1);
        chk_bit(i == 64, gp[1]);
      end
      wr <= 1'b1;
      wd <= i[7:0];
      step(1);
      wr <= 1'b0;
      step(1);
    end
    // A full queue lies above the threshold of 32 tied at the instance.
    cfg(1'b1, rfio_pkg::RFIO_MODE_STDBY, 8'h00);
    chk_bit(1'b1, gp[1]);
    cfg(1'b1, rfio_pkg::RFIO_MODE_STDBY, 8'h04);
    for (int i = 0; i < 64; i++)
    begin
      rd <= 1'b1;
      step(1);
      rd <= 1'b0;
      step(1);
      chk_byte(i[7:0], rdata);
    end
    step(2);
    chk_bit(1'b1, gp[1]);
    cfg(1'b1, rfio_pkg::RFIO_MODE_STDBY, 8'h00);
    chk_bit(1'b0, gp[1]);
    $display("queue test done");
  endtask : t_fifo

  // One byte written in standby leaves MSB first in packet transmit.
  task automatic t_ptx;
    int n = 0;
    logic [7:0] got = 8'h00;
    cfg(1'b1, rfio_pkg::RFIO_MODE_STDBY, 8'h00);
    wr <= 1'b1;
    wd <= 8'hb1;
    step(1);
    wr <= 1'b0;
    cfg(1'b1, rfio_pkg::RFIO_MODE_TX, 8'h00);
    // Idle strobes carry 0, so the byte starts at the first 1 (its MSB).
    while (n < 8)
    begin
      step(1);
      if (stb && (n > 0 || mbit))
      begin
        got = {got[6:0], mbit};
        n++;
      end
    end
    chk_byte(8'hb1, got);
    chk_bit(1'b1, oe);
    $display("packet transmit test done");
  endtask : t_ptx

  task automatic t_ctx;
    int n = 0;
    cfg(1'b0, rfio_pkg::RFIO_MODE_TX, 8'h00);
    while (n < 10)
    begin
      step(1);
      if (stb)
      begin
        n++;
        if (n > 2)
          chk_bit(mcu_d, mbit);
      end
    end
    chk_bit(1'b0, oe);
    $display("stream transmit test done");
  endtask : t_ctx

  task automatic t_crx;
    logic p = 1'b0;
    logic last = 1'b0;
    logic [7:0] pat = 8'h9c;
    demod <= 1'b1;
    cfg(1'b0, rfio_pkg::RFIO_MODE_RX, 8'h00);
    step(2);
    chk_bit(1'b1, gp[2]);
    chk_bit(1'b0, gp[1]);
    chk_bit(1'b1, oe);
    bsync <= 1'b1;
    for (int k = 0; k < 12; k++)
    begin
      while (!(gp[1] && !p))
      begin
        p = gp[1];
        step(1);
      end
      p = 1'b1;
      demod <= pat[7];
      step(1);
      if (k > 1)
        chk_bit(last, mcu_s);
      last = pat[7];
      pat = {pat[6:0], pat[7]};
    end
    $display("stream receive test done");
  endtask : t_crx

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Main sequence.
  initial
  begin
    step(3);
    rst_i <= 1'b0;
    step(1);
    chk_byte(8'h00, {2'h0, gp});
    t_route();
    t_pkt();
    t_fifo();
    t_ptx();
    t_ctx();
    t_crx();
    close_out();
  end
endmodule : rfio_top_tb_top

//--- hw/rfio_consts.svh
// Constants for the radio pin routing and bit-stream port.
// Operation
// - Six general-purpose pins, routed by two configs.
// - Continuous: code and mode pick each source.
// - Packet: pin 0 and pin 1 event sources.
// - Continuous: NRZ bits on data pin directly.
// - Continuous transmit drives bit clock on pin 1.
// - Transmit data captured on bit clock rise.
// - Synchronizer off: raw bits, no bit clock.
// - Synchronizer on: clean data, recovered clock.
// - Data changes on fall, sampled on rise.
// - Packet mode forces the synchronizer on.
// - Packet data passes through FIFO, not pin.
// - Packet engine handles framing inside the device.
// - FIFO usable over SPI in sleep, standby.
// - Full flag high only when all bytes held.
// - FIFO holds exactly 64 one-byte entries.
`ifndef RFIO_CONSTS_SVH
`define RFIO_CONSTS_SVH

`define RFIO_PIN_COUNT 6
`define RFIO_QUEUE_DEPTH 64
`define RFIO_QUEUE_AW 6
`define RFIO_BYTE_BITS 8

// Positions in the internal source vector fed to the pin router.
`define RFIO_S_PAYLOAD 0
`define RFIO_S_PKTDONE 1
`define RFIO_S_CRC 2
`define RFIO_S_MATCH 3
`define RFIO_S_LEADIN 4
`define RFIO_S_TXOK 5
`define RFIO_S_RXOK 6
`define RFIO_S_LOWFLAG 7
`define RFIO_S_LOCK 8
`define RFIO_S_SETTLED 9
`define RFIO_S_DIVIDED_CLOCK_OUT 10
`define RFIO_S_TIMEOUT 11
`define RFIO_S_QTHR 12
`define RFIO_S_QEMPTY 13
`define RFIO_S_QFULL 14
`define RFIO_S_DCLK 15
`define RFIO_S_DATA 16
`define RFIO_S_WIDTH 17

`endif

//--- hw/rfio_fifo.sv
// Byte FIFO for the packet path with a registered read port.
`include "rfio_consts.svh"

module rfio_fifo (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Write side.
  input wire logic wr_i,
  input wire logic [`RFIO_BYTE_BITS-1:0] wdata_i,
  // Read side.
  input wire logic rd_i,
  output logic [`RFIO_BYTE_BITS-1:0] rdata_o,
  // Fill level.
  output logic [`RFIO_QUEUE_AW:0] count_o
);

  logic [`RFIO_BYTE_BITS-1:0] mem_q [`RFIO_QUEUE_DEPTH];
  logic [`RFIO_QUEUE_AW-1:0] wptr_q;
  logic [`RFIO_QUEUE_AW-1:0] rptr_q;
  logic wr_ok;
  logic rd_ok;

  // Writes to a full queue and reads from an empty one are dropped.
  assign wr_ok = wr_i && (count_o != 7'(`RFIO_QUEUE_DEPTH));
  assign rd_ok = rd_i && (count_o != 7'h00);

  // Storage holds 64 bytes; no reset so it maps onto plain RAM.
  always_ff @(posedge clk_i)
  begin
    if (ce_i && wr_ok)
    begin
      mem_q[wptr_q] <= wdata_i;
    end
  end

  // Pointers, level and the registered read data.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr_q <= 6'h00;
      rptr_q <= 6'h00;
      count_o <= 7'h00;
      rdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_ok)
        wptr_q <= wptr_q + 6'h01;
      if (rd_ok)
      begin
        rptr_q <= rptr_q + 6'h01;
        rdata_o <= mem_q[rptr_q];
      end
      if (wr_ok && !rd_ok)
        count_o <= count_o + 7'h01;
      else if (rd_ok && !wr_ok)
        count_o <= count_o - 7'h01;
    end
  end

endmodule : rfio_fifo

//--- hw/rfio_pkg.sv
// Types shared by the radio pin routing block.
package rfio_pkg;

  // Chip mode, Gray coded along sleep, standby, synth, receive, transmit.
  typedef enum logic [2:0] {
    RFIO_MODE_SLEEP = 3'h0,
    RFIO_MODE_STDBY = 3'h1,
    RFIO_MODE_FS = 3'h3,
    RFIO_MODE_RX = 3'h2,
    RFIO_MODE_TX = 3'h6
  } rfio_mode_t;

endpackage : rfio_pkg

//--- hw/rfio_top.sv
// Pin router, continuous bit-stream port and packet byte path.
`include "rfio_consts.svh"

module rfio_top (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Configuration.
  input wire logic [7:0] pin_route_cfg_a_i,
  input wire logic [3:0] pin_route_cfg_b_i,
  input wire rfio_pkg::rfio_mode_t chip_mode_i,
  input wire logic packet_mode_i,
  input wire logic bitsync_en_i,
  input wire logic [5:0] queue_thresh_i,
  // Status sources from the rest of the chip.
  input wire logic rx_payload_avail_i,
  input wire logic tx_packet_done_i,
  input wire logic crc_good_i,
  input wire logic pattern_match_i,
  input wire logic lead_in_seen_i,
  input wire logic transmit_path_ok_i,
  input wire logic receive_path_ok_i,
  input wire logic supply_low_flag_i,
  input wire logic thermal_shift_flag_i,
  input wire logic synth_locked_i,
  input wire logic chip_mode_settled_i,
  input wire logic divided_clock_out_i,
  input wire logic timeout_i,
  // Bit timing and modem bits.
  input wire logic half_bit_tick_i,
  input wire logic demod_bit_i,
  output logic mod_bit_o,
  output logic mod_bit_stb_o,
  // SPI side of the FIFO.
  input wire logic spi_wr_i,
  input wire logic [7:0] spi_wdata_i,
  input wire logic spi_rd_i,
  output logic [7:0] spi_rdata_o,
  // Pins.
  output logic [5:0] gp_pin_o,
  input wire logic gp_pin_2_i,
  output logic gp_pin_2_oe_o,
  output logic bitsync_on_o
);

  logic is_rx;
  logic is_tx;
  logic sync_eff;
  logic clk_active;
  logic rise;
  logic fall;
  logic dclk_q;
  logic data_s1_q;
  logic data_s2_q;
  logic data_out_q;
  logic [7:0] sr_q;
  logic [3:0] cnt_q;
  logic have_q;
  logic load_q;
  logic sr_push;
  logic sr_pop;
  logic q_wr;
  logic q_rd;
  logic [7:0] q_wdata;
  logic [6:0] q_count;
  logic [`RFIO_S_WIDTH-1:0] src;
  logic [`RFIO_PIN_COUNT-1:0] pin_d;

  assign is_rx = (chip_mode_i == rfio_pkg::RFIO_MODE_RX);
  assign is_tx = (chip_mode_i == rfio_pkg::RFIO_MODE_TX);
  // Packet mode always runs the synchronizer, whatever software chose.
  assign sync_eff = packet_mode_i | bitsync_en_i;
  // The bit clock runs in transmit, and in receive only with the synchronizer.
  assign clk_active = is_tx | (is_rx & sync_eff);
  assign rise = ce_i & half_bit_tick_i & clk_active & !dclk_q;
  assign fall = ce_i & half_bit_tick_i & clk_active & dclk_q;

  // Returns the source of one pin for its code, the chip mode and data mode.
  function automatic logic route(input logic [2:0] p, input logic [1:0] c,
                                 input rfio_pkg::rfio_mode_t m, input logic pkt,
                                 input logic [`RFIO_S_WIDTH-1:0] s);
    logic rx;
    logic tx;
    logic act;
    rx = (m == rfio_pkg::RFIO_MODE_RX);
    tx = (m == rfio_pkg::RFIO_MODE_TX);
    act = rx | tx | (m == rfio_pkg::RFIO_MODE_FS);
    route = 1'b0;
    if (!pkt)
    begin
      case ({p, c})
        5'h00: route = (rx & s[`RFIO_S_MATCH]) | (tx & s[`RFIO_S_TXOK]);
        5'h01: route = rx & s[`RFIO_S_LEADIN];
        5'h02: route = (rx & s[`RFIO_S_RXOK]) | (tx & s[`RFIO_S_TXOK]);
        5'h04: route = (rx | tx) & s[`RFIO_S_DCLK];
        5'h05: route = rx & s[`RFIO_S_LEADIN];
        5'h08, 5'h09, 5'h0a, 5'h0b: route = s[`RFIO_S_DATA];
        5'h0c: route = rx & s[`RFIO_S_TIMEOUT];
        5'h0d: route = rx & s[`RFIO_S_LEADIN];
        5'h0f: route = s[`RFIO_S_LOWFLAG];
        5'h10: route = act & s[`RFIO_S_LOWFLAG];
        5'h11: route = act & s[`RFIO_S_LOCK];
        5'h12: route = rx & s[`RFIO_S_TIMEOUT];
        5'h13: route = s[`RFIO_S_SETTLED];
        5'h14: route = s[`RFIO_S_DIVIDED_CLOCK_OUT];
        5'h15: route = act & s[`RFIO_S_LOCK];
        5'h16: route = rx & s[`RFIO_S_LEADIN];
        5'h17: route = s[`RFIO_S_SETTLED];
        default: route = 1'b0;
      endcase
    end
    else
    begin
      case ({p, c})
        5'h00: route = (rx & s[`RFIO_S_PAYLOAD]) | (tx & s[`RFIO_S_PKTDONE]);
        5'h01: route = rx & s[`RFIO_S_CRC];
        5'h03: route = s[`RFIO_S_LOWFLAG];
        5'h04: route = s[`RFIO_S_QTHR];
        5'h05: route = s[`RFIO_S_QEMPTY];
        5'h06: route = s[`RFIO_S_QFULL];
        5'h08: route = s[`RFIO_S_QFULL];
        5'h09: route = rx & s[`RFIO_S_RXOK];
        5'h0a: route = rx ? s[`RFIO_S_TIMEOUT] : s[`RFIO_S_QFULL];
        5'h0b: route = rx ? s[`RFIO_S_MATCH] : s[`RFIO_S_QFULL];
        5'h0d: route = tx & s[`RFIO_S_TXOK];
        5'h0c, 5'h0e, 5'h0f: route = s[`RFIO_S_QEMPTY];
        5'h10: route = act & s[`RFIO_S_LOWFLAG];
        5'h11: route = act & s[`RFIO_S_LOCK];
        5'h12: route = rx & s[`RFIO_S_TIMEOUT];
        5'h13: route = rx & s[`RFIO_S_LEADIN];
        5'h14: route = s[`RFIO_S_DIVIDED_CLOCK_OUT];
        5'h15: route = act & s[`RFIO_S_LOCK];
        5'h17: route = s[`RFIO_S_SETTLED];
        default: route = 1'b0;
      endcase
    end
  endfunction : route

  // Gather every candidate source into one vector for the router.
  always_comb
  begin
    src = '0;
    src[`RFIO_S_PAYLOAD] = rx_payload_avail_i;
    src[`RFIO_S_PKTDONE] = tx_packet_done_i;
    src[`RFIO_S_CRC] = crc_good_i;
    src[`RFIO_S_MATCH] = pattern_match_i;
    src[`RFIO_S_LEADIN] = lead_in_seen_i;
    src[`RFIO_S_TXOK] = transmit_path_ok_i;
    src[`RFIO_S_RXOK] = receive_path_ok_i;
    src[`RFIO_S_LOWFLAG] = supply_low_flag_i | thermal_shift_flag_i;
    src[`RFIO_S_LOCK] = synth_locked_i;
    src[`RFIO_S_SETTLED] = chip_mode_settled_i;
    src[`RFIO_S_DIVIDED_CLOCK_OUT] = divided_clock_out_i;
    src[`RFIO_S_TIMEOUT] = timeout_i;
    src[`RFIO_S_QTHR] = (q_count > {1'b0, queue_thresh_i});
    src[`RFIO_S_QEMPTY] = (q_count == 7'h00);
    src[`RFIO_S_QFULL] = (q_count == 7'(`RFIO_QUEUE_DEPTH));
    src[`RFIO_S_DCLK] = dclk_q;
    src[`RFIO_S_DATA] = data_out_q;
  end

  // One router per pin; codes for pins 0-3 sit in config a, 4-5 in config b.
  genvar gi;
  generate
    for (gi = 0; gi < `RFIO_PIN_COUNT; gi++)
    begin : g_pin
      logic [1:0] code;
      if (gi < 4)
      begin : g_a
        assign code = pin_route_cfg_a_i[2*gi+1:2*gi];
      end
      else
      begin : g_b
        assign code = pin_route_cfg_b_i[2*(gi-4)+1:2*(gi-4)];
      end
      assign pin_d[gi] = route(3'(gi), code, chip_mode_i, packet_mode_i, src);
    end
  endgenerate

  // Registering every pin hides mux switching hazards from the outside.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gp_pin_o <= 6'h00;
      gp_pin_2_oe_o <= 1'b0;
      bitsync_on_o <= 1'b0;
    end
    else if (ce_i)
    begin
      gp_pin_o <= pin_d;
      // The data pin is an input only during continuous transmit.
      gp_pin_2_oe_o <= packet_mode_i | !is_tx;
      bitsync_on_o <= sync_eff;
    end
  end

  // Two-stage synchroniser for the data pin driven by the controller.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_s1_q <= 1'b0;
      data_s2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      data_s1_q <= gp_pin_2_i;
      data_s2_q <= data_s1_q;
    end
  end

  // Bit clock toggles on each half-bit tick while it is wanted, else low.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dclk_q <= 1'b0;
    else if (ce_i)
    begin
      if (!clk_active)
        dclk_q <= 1'b0;
      else if (half_bit_tick_i)
        dclk_q <= !dclk_q;
    end
  end

  // Receive data onto the pin: raw when unsynchronised, else on the fall.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      data_out_q <= 1'b0;
    else if (ce_i && !packet_mode_i)
    begin
      if (is_rx && !sync_eff)
        data_out_q <= demod_bit_i;
      else if (fall && is_rx)
        data_out_q <= demod_bit_i;
    end
  end

  // Modulator bit: pin sample in continuous, FIFO byte MSB first in packet.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mod_bit_o <= 1'b0;
      mod_bit_stb_o <= 1'b0;
    end
    else if (ce_i)
    begin
      mod_bit_stb_o <= rise & is_tx;
      if (rise && is_tx)
      begin
        if (!packet_mode_i)
          mod_bit_o <= data_s2_q;
        else
          mod_bit_o <= have_q & sr_q[7];
      end
    end
  end

  // Packet shift register: deserialises in receive, serialises in transmit.
  assign sr_push = rise & is_rx & packet_mode_i & (cnt_q == 4'h7);
  assign sr_pop = ce_i & is_tx & packet_mode_i & !have_q & !load_q & (q_count != 7'h00);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sr_q <= 8'h00;
      cnt_q <= 4'h0;
      have_q <= 1'b0;
      load_q <= 1'b0;
    end
    else if (ce_i)
    begin
      load_q <= sr_pop;
      if (!packet_mode_i || !(is_rx || is_tx))
      begin
        cnt_q <= 4'h0;
        have_q <= 1'b0;
      end
      else if (is_rx && rise)
      begin
        sr_q <= {sr_q[6:0], demod_bit_i};
        cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
      end
      else if (is_tx && load_q)
      begin
        sr_q <= spi_rdata_o;
        cnt_q <= 4'h8;
        have_q <= 1'b1;
      end
      else if (is_tx && rise && have_q)
      begin
        sr_q <= {sr_q[6:0], 1'b0};
        cnt_q <= cnt_q - 4'h1;
        have_q <= (cnt_q != 4'h1);
      end
    end
  end

  // Modem side writes the FIFO in packet receive and reads it in packet transmit; SPI has every other port.
  assign q_wr = (packet_mode_i & is_rx) ? sr_push : spi_wr_i;
  assign q_wdata = (packet_mode_i & is_rx) ? {sr_q[6:0], demod_bit_i} : spi_wdata_i;
  assign q_rd = (packet_mode_i & is_tx) ? sr_pop : (ce_i & spi_rd_i);

  rfio_fifo u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_i(q_wr),
    .wdata_i(q_wdata),
    .rd_i(q_rd),
    .rdata_o(spi_rdata_o),
    .count_o(q_count)
  );

endmodule : rfio_top
